// *** hdl/ict_sequencer.sv ***
// Purpose: Instruction cycle sequencer and external bus timing
// Assumes: External code and data memory on the multiplexed bus
// Notes: Outputs lead internal state by nothing; all are registered
`timescale 1ns/1ps
module ict_sequencer (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [7:0] low_addr_data_port_in,
    input wire logic [2:0] stretch_sel_in,
    input wire logic [7:0] acc_in,
    input wire logic [7:0] work_reg_zero_in,
    input wire logic [7:0] work_reg_one_in,
    input wire logic [7:0] high_addr_latch_in,
    input wire logic branch_taken_in,
    output ict_pkg::ict_pad_type low_addr_data_port_out,
    output logic [7:0] high_addr_port_out,
    output logic ale_out,
    output logic code_strobe_n_out,
    output logic rd_n_out,
    output logic wr_n_out,
    output logic instr_done_out,
    output logic illegal_op_out,
    output logic [7:0] opcode_out,
    output logic [7:0] indirect_addr_out,
    output logic [15:0] branch_target_out,
    output logic [7:0] xdata_read_out,
    output logic xdata_valid_out,
    output logic [15:0] data_pointer_out,
    output logic pointer_select_bit_out
);
    logic [1:0] phase;
    logic [1:0] next_phase;
    logic mc_end;
    logic [7:0] pad_meta;
    logic [7:0] pad_sync;
    ict_pkg::ict_state_type state;
    ict_pkg::ict_state_type next_state;
    logic [7:0] opcode;
    logic [7:0] op1;
    logic [7:0] op2;
    logic [15:0] pc;
    logic [15:0] next_pc;
    logic [3:0] mc_left;
    logic [3:0] next_mc_left;
    logic [1:0] bytes_left;
    logic [1:0] next_bytes;
    logic done_w;
    logic [15:0] first_data_pointer;
    logic [15:0] second_data_pointer;
    logic pointer_select_bit;
    ict_pkg::ict_decode_type dec;

    ict_phase_gen u_phase (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .phase_out(phase),
        .next_phase_out(next_phase),
        .mc_end_out(mc_end)
    );

    // The opcode is decoded straight off the bus in its own fetch cycle
    wire in_opcode = (state == ict_pkg::ST_OPCODE);
    wire in_fetch = in_opcode || (state == ict_pkg::ST_OPERAND);
    wire [7:0] dec_src = in_opcode ? pad_sync : opcode;

    ict_cycle_table u_table (
        .opcode_in(dec_src),
        .entry_out(dec)
    );

    wire [3:0] stretch = dec.xmove ? {1'b0, stretch_sel_in} : 4'h0;
    wire [3:0] mc_total = {1'b0, dec.mc} + stretch; // [RULE7] [RULE17]
    wire [15:0] active_ptr =
        pointer_select_bit ? second_data_pointer : first_data_pointer;
    wire [7:0] ri_val = dec_src[0] ? work_reg_one_in : work_reg_zero_in;
    wire [15:0] xaddr = dec.xptr ? active_ptr
                                 : {high_addr_latch_in, ri_val}; // [RULE9]
    // The last operand is still on its way into op1/op2 when done fires
    wire grab_op = mc_end && (state == ict_pkg::ST_OPERAND);
    wire grab_one = grab_op && (bytes_left == dec.nbytes - 2'd1);
    wire [7:0] op1_now = grab_one ? pad_sync : op1;
    wire [7:0] op2_now = (grab_op && !grab_one) ? pad_sync : op2;
    wire [7:0] rel_byte = (dec.nbytes == 2'd3) ? op2 : op1;
    wire [15:0] rel_target =
        pc + {{8{rel_byte[7]}}, rel_byte}; // [RULE12]
    wire take_rel = done_w && dec.rel && branch_taken_in;
    wire fetch_nx = (next_state == ict_pkg::ST_OPCODE) ||
                    (next_state == ict_pkg::ST_OPERAND);
    wire xd_nx = (next_state == ict_pkg::ST_XDATA);
    wire addr_phase = (next_phase == 2'h0);
    wire bump_sel = done_w && (dec_src == ict_pkg::OP_INC_DIRECT) &&
                    (op1_now == ict_pkg::SEL_REG_ADDR);
    wire load_ptr = done_w && (dec_src == ict_pkg::OP_LOAD_PTR);
    wire inc_ptr = done_w && (dec_src == ict_pkg::OP_INC_PTR);
    wire [15:0] new_ptr =
        load_ptr ? {op1_now, op2_now} : active_ptr + 16'h0001;
    wire xread_end = mc_end && (state == ict_pkg::ST_XDATA) &&
                     (mc_left == 4'h1) && !dec.xwrite;

    always_comb begin
        next_mc_left = mc_left;
        next_bytes = bytes_left;
        done_w = 1'b0;
        if (mc_end) begin
            if (in_opcode) begin
                next_mc_left = mc_total - 4'h1; // [RULE17]
                next_bytes = dec.nbytes - 2'd1; // [RULE3]
                done_w = (mc_total == 4'h1);
            end else begin
                done_w = (mc_left == 4'h1); // [RULE4]
                if (!done_w) next_mc_left = mc_left - 4'h1;
                if (state == ict_pkg::ST_OPERAND) begin
                    next_bytes = bytes_left - 2'd1;
                end
            end
        end
    end

    always_comb begin
        next_state = state;
        if (mc_end) begin
            if (done_w) begin
                next_state = ict_pkg::ST_OPCODE;
            end else if (next_bytes != 2'd0) begin
                next_state = ict_pkg::ST_OPERAND;
            end else if (dec.xmove) begin
                next_state = ict_pkg::ST_XDATA;
            end else begin
                next_state = ict_pkg::ST_IDLE;
            end
        end
    end

    // Code fetches advance the counter once per fetch cycle, never stretched
    always_comb begin
        next_pc = pc;
        if (mc_end && in_fetch) next_pc = pc + 16'h0001; // [RULE8]
        if (take_rel) next_pc = rel_target; // [RULE12]
    end

    // Pin inputs pass two flops before any use
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pad_meta <= 8'h00;
            pad_sync <= 8'h00;
        end else begin
            pad_meta <= low_addr_data_port_in;
            pad_sync <= pad_meta;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            state <= ict_pkg::ST_OPCODE;
            pc <= ict_pkg::PC_RESET;
            mc_left <= 4'h0;
            bytes_left <= 2'd0;
            opcode <= 8'h00;
        end else begin
            state <= next_state;
            pc <= next_pc;
            mc_left <= next_mc_left;
            bytes_left <= next_bytes;
            if (mc_end && in_opcode) opcode <= pad_sync;
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            op1 <= 8'h00;
            op2 <= 8'h00;
        end else if (mc_end && state == ict_pkg::ST_OPERAND) begin
            if (bytes_left == dec.nbytes - 2'd1) begin
                op1 <= pad_sync;
            end else begin
                op2 <= pad_sync;
            end
        end
    end

    // Incrementing the select register only flips its one live bit
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            pointer_select_bit <= ict_pkg::PTR_SEL_RESET; // [RULE13]
            first_data_pointer <= ict_pkg::PTR_RESET;
            second_data_pointer <= ict_pkg::PTR_RESET;
        end else begin
            if (bump_sel) pointer_select_bit <= ~pointer_select_bit;
            if ((load_ptr || inc_ptr) && !pointer_select_bit) begin
                first_data_pointer <= new_ptr; // [RULE13]
            end
            if ((load_ptr || inc_ptr) && pointer_select_bit) begin
                second_data_pointer <= new_ptr;
            end
        end
    end

    // Bus pins: ALE and address in phase zero, strobes in phases one..three.
    // Reset parks the first fetch address under ALE. Stretched data cycles
    // re-strobe ALE with the same data address driven again each time.
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ale_out <= 1'b1;
            code_strobe_n_out <= 1'b1;
            rd_n_out <= 1'b1;
            wr_n_out <= 1'b1;
            low_addr_data_port_out <=
                '{data: ict_pkg::PC_RESET[7:0], oe_n: 1'b0};
            high_addr_port_out <= ict_pkg::PC_RESET[15:8];
        end else begin
            ale_out <= addr_phase; // [RULE2]
            code_strobe_n_out <= !(fetch_nx && !addr_phase);
            rd_n_out <= !(xd_nx && !dec.xwrite && !addr_phase);
            wr_n_out <= !(xd_nx && dec.xwrite && !addr_phase);
            if (addr_phase) begin
                low_addr_data_port_out.data <=
                    fetch_nx ? next_pc[7:0] : xaddr[7:0]; // [RULE9]
                low_addr_data_port_out.oe_n <= 1'b0;
            end else if (xd_nx && dec.xwrite) begin
                low_addr_data_port_out.data <= acc_in;
                low_addr_data_port_out.oe_n <= 1'b0;
            end else begin
                low_addr_data_port_out.oe_n <= 1'b1;
            end
            high_addr_port_out <= fetch_nx ? next_pc[15:8] : xaddr[15:8];
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            instr_done_out <= 1'b0;
            illegal_op_out <= 1'b0;
            opcode_out <= 8'h00;
            indirect_addr_out <= 8'h00;
            branch_target_out <= ict_pkg::PC_RESET;
            xdata_read_out <= 8'h00;
            xdata_valid_out <= 1'b0;
        end else begin
            instr_done_out <= done_w;
            xdata_valid_out <= xread_end; // [RULE7]
            if (xread_end) xdata_read_out <= pad_sync;
            if (done_w) begin
                opcode_out <= dec_src;
                illegal_op_out <= !dec.legal; // [RULE10]
                indirect_addr_out <= ri_val; // [RULE11]
                branch_target_out <= rel_target;
            end
        end
    end

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            data_pointer_out <= ict_pkg::PTR_RESET;
            pointer_select_bit_out <= ict_pkg::PTR_SEL_RESET;
        end else begin
            data_pointer_out <= active_ptr;
            pointer_select_bit_out <= pointer_select_bit;
        end
    end

    // Checking helpers: clocks and fetch cycles spent on this instruction
    logic [5:0] clk_cnt;
    logic [2:0] fetch_cnt;
    logic [2:0] stretch_lat;
    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            clk_cnt <= 6'h00;
            fetch_cnt <= 3'h0;
            stretch_lat <= 3'h0;
        end else begin
            clk_cnt <= done_w ? 6'h00 : clk_cnt + 6'h01;
            if (done_w) fetch_cnt <= 3'h0;
            else if (mc_end && in_fetch) fetch_cnt <= fetch_cnt + 3'h1;
            if (mc_end && in_opcode) stretch_lat <= stretch_sel_in;
        end
    end
    wire [2:0] fetch_total = fetch_cnt + {2'b00, in_fetch};
    wire [5:0] xmove_last = 6'(4 * (2 + stretch_lat) - 1);

    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    sequence s_quiet_three;
        !mc_end [*3];
    endsequence
    sequence s_ale_gap;
        !ale_out [*3] ##1 ale_out;
    endsequence

    a_mc_four_clocks: assert property ( // [RULE1]
        mc_end |=> s_quiet_three ##1 mc_end)
        else $error("machine cycle not four clocks");
    a_whole_mc_count: assert property ( // [RULE1]
        done_w |-> clk_cnt[1:0] == 2'd3)
        else $error("instruction not whole machine cycles");
    a_ale_each_mc: assert property ( // [RULE2]
        ale_out |=> s_ale_gap)
        else $error("address strobe not once per machine cycle");
    a_fetch_per_byte: assert property ( // [RULE3]
        done_w |-> fetch_total == {1'b0, dec.nbytes})
        else $error("fetch cycles differ from byte count");
    a_len_one_five: assert property ( // [RULE4]
        done_w && !dec.xmove |-> clk_cnt <= 6'd19)
        else $error("instruction longer than five cycles");
    a_xmove_span: assert property ( // [RULE7]
        done_w && dec.xmove |-> clk_cnt == xmove_last)
        else $error("external move length wrong");
    a_xmove_fast: assert property ( // [RULE5]
        done_w && dec.xmove && stretch_lat == 3'h0 |-> clk_cnt == 6'd7)
        else $error("fastest external move not eight clocks");
    a_move_dd: assert property ( // [RULE6]
        done_w && dec_src == ict_pkg::OP_MOVE_DD |-> clk_cnt == 6'd11)
        else $error("direct move not twelve clocks");
    a_mul_div: assert property ( // [RULE14]
        done_w && (dec_src == ict_pkg::OP_MULTIPLY ||
        dec_src == ict_pkg::OP_DIVIDE) |-> clk_cnt == 6'd19)
        else $error("multiply or divide not twenty clocks");
    a_ptr_table: assert property ( // [RULE15]
        done_w && (dec_src == ict_pkg::OP_INC_PTR ||
        dec_src == ict_pkg::OP_TABLE_PC ||
        dec_src == ict_pkg::OP_TABLE_PTR) |-> clk_cnt == 6'd11)
        else $error("pointer op not twelve clocks");
    a_call_return: assert property ( // [RULE16]
        done_w && (dec_src == ict_pkg::OP_LONG_CALL ||
        dec_src == ict_pkg::OP_SUB_RETURN ||
        dec_src == ict_pkg::OP_INT_RETURN) |-> clk_cnt == 6'd15)
        else $error("call or return not sixteen clocks");
    a_sel_flip: assert property ( // [RULE13]
        bump_sel |=> ##1
        pointer_select_bit_out != $past(pointer_select_bit, 2))
        else $error("select bit did not switch");
    a_illegal_only: assert property ( // [RULE10]
        instr_done_out && illegal_op_out |-> opcode_out == ict_pkg::OP_UNDEF)
        else $error("defined opcode flagged illegal");
    a_addr_driven: assert property ( // [RULE9]
        ale_out |-> !low_addr_data_port_out.oe_n && code_strobe_n_out)
        else $error("address not driven under strobe");
endmodule

// *** common/ict_pkg.sv ***
// Purpose: Shared constants and types for the instruction cycle sequencer
// Assumes: One 250 MHz clock; every machine cycle is four clocks
// Notes: Logic that carries a rule is marked with its tag
// Overview of operation
// RULE1 - Machine cycle is exactly four clocks
// RULE2 - One address latch strobe every machine cycle
// RULE3 - One machine cycle per fetched byte
// RULE4 - Instructions take one to five machine cycles
// RULE5 - Fastest external read takes eight clocks
// RULE6 - Direct to direct move takes twelve clocks
// RULE7 - External data move spans 8 to 36 clocks
// RULE8 - Code fetch rate never stretched
// RULE9 - Multiplexed low address/data, separate high address
// RULE10 - 255 opcodes decoded, one left undefined
// RULE11 - Indirect address from working register zero/one
// RULE12 - Relative offset is signed byte added
// RULE13 - Two pointers, select bit, reset selects first
// RULE14 - Multiply and divide take twenty clocks
// RULE15 - Pointer increment, table reads take twelve clocks
// RULE16 - Long call/returns sixteen, short branches twelve
// RULE17 - Cycle counter from table, stretch external moves
package ict_pkg;
    localparam int CLK_PER_MC = 4;
    localparam int XMOVE_MIN_CLK = 8;
    localparam int XMOVE_MAX_CLK = 36;
    localparam logic [2:0] XMOVE_BASE_MC = 3'(XMOVE_MIN_CLK / CLK_PER_MC);
    localparam logic [2:0] STRETCH_MAX =
        3'((XMOVE_MAX_CLK - XMOVE_MIN_CLK) / CLK_PER_MC);
    localparam logic [1:0] PHASE_LAST = 2'(CLK_PER_MC - 1);
    localparam logic [7:0] SEL_REG_ADDR = 8'h86;
    localparam logic PTR_SEL_RESET = 1'b0;
    localparam logic [15:0] PC_RESET = 16'h0000;
    localparam logic [15:0] PTR_RESET = 16'h0000;
    localparam logic [7:0] OP_UNDEF = 8'hA5;
    localparam logic [7:0] OP_INC_DIRECT = 8'h05;
    localparam logic [7:0] OP_LOAD_PTR = 8'h90;
    localparam logic [7:0] OP_INC_PTR = 8'hA3;
    localparam logic [7:0] OP_MULTIPLY = 8'hA4;
    localparam logic [7:0] OP_DIVIDE = 8'h84;
    localparam logic [7:0] OP_MOVE_DD = 8'h85;
    localparam logic [7:0] OP_LONG_CALL = 8'h12;
    localparam logic [7:0] OP_SUB_RETURN = 8'h22;
    localparam logic [7:0] OP_INT_RETURN = 8'h32;
    localparam logic [7:0] OP_TABLE_PC = 8'h83;
    localparam logic [7:0] OP_TABLE_PTR = 8'h93;

    typedef enum logic [3:0] {
        ST_OPCODE = 4'b0001,
        ST_OPERAND = 4'b0010,
        ST_IDLE = 4'b0100,
        ST_XDATA = 4'b1000
    } ict_state_type;

    typedef struct packed {
        logic legal;
        logic [2:0] mc;
        logic [1:0] nbytes;
        logic xmove;
        logic xwrite;
        logic xptr;
        logic rel;
        logic ri;
    } ict_decode_type;

    typedef struct packed {
        logic [7:0] data;
        logic oe_n;
    } ict_pad_type;
endpackage

// *** hdl/ict_phase_gen.sv ***
// Purpose: Divides the clock into four-phase machine cycles
// Assumes: Reset starts the cycle at phase zero
// Notes: mc_end_out pulses on the last clock of each machine cycle
`timescale 1ns/1ps
module ict_phase_gen (
    input wire logic clk_in,
    input wire logic rst_n_in,
    output logic [1:0] phase_out,
    output logic [1:0] next_phase_out,
    output logic mc_end_out
);
    assign mc_end_out = (phase_out == ict_pkg::PHASE_LAST);
    assign next_phase_out = mc_end_out ? 2'h0 : phase_out + 2'h1;

    always_ff @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            phase_out <= 2'h0;
        end else begin
            phase_out <= next_phase_out; // [RULE1]
        end
    end
endmodule

// *** hdl/ict_cycle_table.sv ***
// Purpose: Opcode decode table of machine cycles, length and operand kind
// Assumes: Purely combinational
// Notes: Only one opcode value is left undefined
`timescale 1ns/1ps
module ict_cycle_table (
    input wire logic [7:0] opcode_in,
    output ict_pkg::ict_decode_type entry_out
);
    wire [3:0] hi = opcode_in[7:4];
    wire [3:0] lo = opcode_in[3:0];
    wire xcol = (lo == 4'h0) || (lo == 4'h2) || (lo == 4'h3);

    function automatic ict_pkg::ict_decode_type mk(input logic [2:0] mc,
        input logic [1:0] nb, input logic rel);
        ict_pkg::ict_decode_type e;
        e = '0;
        e.legal = 1'b1;
        e.mc = mc;
        e.nbytes = nb;
        e.rel = rel;
        return e;
    endfunction

    always_comb begin
        entry_out = mk(3'd1, 2'd1, 1'b0);
        if (hi[3:1] == 3'b111 && xcol) begin
            entry_out.mc = ict_pkg::XMOVE_BASE_MC; // [RULE5]
            entry_out.xmove = 1'b1;
            entry_out.xwrite = hi[0];
            entry_out.xptr = (lo == 4'h0);
            entry_out.ri = (lo != 4'h0);
        end else if (lo >= 4'h6) begin
            case (hi)
                4'h7, 4'h8, 4'hA: entry_out = mk(3'd2, 2'd2, 1'b0);
                4'hB: entry_out = mk(3'd4, 2'd3, 1'b1);
                4'hD: if (lo >= 4'h8) entry_out = mk(3'd3, 2'd2, 1'b1);
                default: entry_out = mk(3'd1, 2'd1, 1'b0);
            endcase
            entry_out.ri = (lo < 4'h8); // [RULE11]
        end else if (lo == 4'h5) begin
            case (hi)
                4'h7, 4'h8: entry_out = mk(3'd3, 2'd3, 1'b0); // [RULE6]
                4'hB, 4'hD: entry_out = mk(3'd4, 2'd3, 1'b1);
                4'hA: entry_out.legal = 1'b0; // [RULE10]
                default: entry_out = mk(3'd2, 2'd2, 1'b0);
            endcase
        end else if (lo == 4'h4) begin
            case (hi)
                4'h0, 4'h1, 4'hC, 4'hD, 4'hE, 4'hF: ;
                4'h8, 4'hA: entry_out = mk(3'd5, 2'd1, 1'b0); // [RULE14]
                4'hB: entry_out = mk(3'd4, 2'd3, 1'b1);
                default: entry_out = mk(3'd2, 2'd2, 1'b0);
            endcase
        end else if (lo == 4'h3) begin
            case (hi)
                4'h4, 4'h5, 4'h6: entry_out = mk(3'd3, 2'd3, 1'b0);
                4'h7, 4'h8, 4'h9, 4'hA:
                    entry_out = mk(3'd3, 2'd1, 1'b0); // [RULE15]
                default: ;
            endcase
        end else if (lo == 4'h2) begin
            case (hi)
                4'h0, 4'h1: entry_out = mk(3'd4, 2'd3, 1'b0); // [RULE16]
                4'h2, 4'h3: entry_out = mk(3'd4, 2'd1, 1'b0); // [RULE16]
                default: entry_out = mk(3'd2, 2'd2, 1'b0);
            endcase
        end else if (lo == 4'h1) begin
            entry_out = mk(3'd3, 2'd2, 1'b0); // [RULE16]
        end else begin
            case (hi)
                4'h0: ;
                4'h1, 4'h2, 4'h3: entry_out = mk(3'd4, 2'd3, 1'b1);
                4'h4, 4'h5, 4'h6, 4'h7, 4'h8:
                    entry_out = mk(3'd3, 2'd2, 1'b1); // [RULE16]
                4'h9: entry_out = mk(3'd3, 2'd3, 1'b0);
                default: entry_out = mk(3'd2, 2'd2, 1'b0);
            endcase
        end
    end
endmodule

// *** tb/ict_ext_mem.sv ***
// Purpose: Behavioural external code and data memory on the shared bus
// Assumes: Low address byte is taken while the device drives the bus
// Notes: Only the low address byte indexes the arrays
`timescale 1ns/1ps
module ict_ext_mem (
    input wire logic clk_in,
    input wire logic ale_in,
    input wire ict_pkg::ict_pad_type pad_in,
    input wire logic code_strobe_n_in,
    input wire logic rd_n_in,
    input wire logic wr_n_in,
    input wire logic [7:0] bus_in,
    output logic [7:0] data_out
);
    logic [7:0] code_mem [0:255];
    logic [7:0] xdata [0:255];
    logic [7:0] addr_lo = 8'h00;
    logic [7:0] last = 8'h00;

    // A released bus shows a moving pattern, never a held copy
    assign data_out = !code_strobe_n_in ? code_mem[addr_lo] :
        (!rd_n_in ? xdata[addr_lo] : ~last);

    always @(posedge clk_in) begin
        last <= bus_in;
        if (ale_in && !pad_in.oe_n) begin
            addr_lo <= bus_in;
        end
        if (!wr_n_in && !pad_in.oe_n) begin
            xdata[addr_lo] <= bus_in;
        end
    end
endmodule

// *** tb/instruction_cycle_timing_tb_top.sv ***
// Purpose: Self-checking bench for the instruction cycle sequencer
// Assumes: Program runs from external memory, starting at address zero
// Notes: Three passes with different stretch; later resets hit mid-run
`timescale 1ns/1ps
module instruction_cycle_timing_tb_top;
    localparam int N = 23;
    localparam int LIMIT = 7000;
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic [2:0] stretch = 3'h0;
    logic [7:0] acc = 8'h00, r0 = 8'h00, r1 = 8'h00, hi = 8'h00;
    logic taken = 1'b0;
    logic [7:0] bus, mem_data, high_addr, opcode, ind_addr, xread;
    ict_pkg::ict_pad_type pad;
    logic ale, cs_n, rd_n, wr_n, done, illegal, xvalid, sel;
    logic [15:0] target, data_pointer;
    int failures = 0, checked = 0, cycles = 0;
    int idx = N, cnt, n_ale, n_str, n_cs, pc, s_cur;
    logic [7:0] rd_q [$];
    logic [7:0] prog [0:33] = '{8'h00, 8'h90, 8'h00, 8'h40, 8'hE0, 8'hA3,
        8'hF0, 8'h05, 8'h86, 8'h00, 8'h90, 8'h00, 8'h50, 8'h05, 8'h86, 8'hA4,
        8'h84, 8'h85, 8'h30, 8'h31, 8'h12, 8'h00, 8'h00, 8'h22, 8'h32, 8'h83,
        8'h93, 8'hA5, 8'hE6, 8'hE7, 8'hE2, 8'h60, 8'hF0, 8'h00};
    int len [N] = '{1, 3, 1, 1, 1, 2, 1, 3, 2, 1, 1, 3, 3, 1, 1, 1, 1, 1, 1,
        1, 1, 2, 1};
    // Zero marks an external data move, whose length follows the stretch
    int base [N] = '{4, 12, 0, 12, 0, 8, 4, 12, 8, 20, 20, 12, 16, 16, 16,
        12, 12, 4, 4, 4, 0, 12, 4};

    always #2 clk_in = ~clk_in;
    assign bus = !pad.oe_n ? pad.data : mem_data;

    ict_sequencer dut (
        .clk_in(clk_in), .rst_n_in(rst_n_in),
        .low_addr_data_port_in(bus), .stretch_sel_in(stretch),
        .acc_in(acc), .work_reg_zero_in(r0), .work_reg_one_in(r1),
        .high_addr_latch_in(hi), .branch_taken_in(taken),
        .low_addr_data_port_out(pad), .high_addr_port_out(high_addr),
        .ale_out(ale), .code_strobe_n_out(cs_n), .rd_n_out(rd_n),
        .wr_n_out(wr_n), .instr_done_out(done), .illegal_op_out(illegal),
        .opcode_out(opcode), .indirect_addr_out(ind_addr),
        .branch_target_out(target), .xdata_read_out(xread),
        .xdata_valid_out(xvalid), .data_pointer_out(data_pointer),
        .pointer_select_bit_out(sel));

    ict_ext_mem mem (
        .clk_in(clk_in), .ale_in(ale), .pad_in(pad),
        .code_strobe_n_in(cs_n), .rd_n_in(rd_n), .wr_n_in(wr_n),
        .bus_in(bus), .data_out(mem_data));

    task automatic check(input string what, input logic [15:0] seen,
            input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic conclude();
        $display("checked %0d failures %0d", checked, failures);
        if (failures == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic on_done();
        logic [7:0] op;
        int ec;
        op = prog[pc];
        ec = (base[idx] == 0) ? 8 + 4 * s_cur : base[idx];
        check("opcode", 16'(opcode), 16'(op));
        check("illegal", 16'(illegal), 16'(op == 8'hA5));
        if (idx > 0) begin
            check("clocks", 16'(cnt), 16'(ec));
            check("ale count", 16'(n_ale), 16'(ec / 4));
            check("strobe", 16'(n_str), 16'(base[idx] == 0 ?
                3 * (1 + s_cur) : 0));
            check("fetches", 16'(n_cs), 16'(3 * len[idx]));
        end
        if (idx == 4) check("written", 16'(mem.xdata[8'h41]), 16'(acc));
        if (idx == 18) check("indirect", 16'(ind_addr), 16'(r0));
        if (idx == 19) check("indirect", 16'(ind_addr), 16'(r1));
        if (idx == 21) check("target", target, 16'(pc + 2 - 16));
        if (idx == 0 || idx == 9) check("select", 16'(sel), 16'h0000);
        if (idx == 6) check("select", 16'(sel), 16'h0001);
        if (idx == 6) check("pointer", data_pointer, 16'h0000);
        if (idx == 9) check("pointer", data_pointer, 16'h0041);
        pc += len[idx];
        idx++;
        cnt = 0;
        n_ale = 0;
        n_str = 0;
        n_cs = 0;
    endtask

    always @(posedge clk_in) begin
        cycles++;
        if (cycles == LIMIT) begin
            failures++;
            conclude();
        end
        if (rst_n_in && idx < N) begin
            cnt++;
            if (ale === 1'b1) n_ale++;
            if (rd_n === 1'b0 || wr_n === 1'b0) n_str++;
            if (cs_n === 1'b0) n_cs++;
            if (ale === 1'b1 && idx == 20 && done !== 1'b1) begin
                check("xaddr", {high_addr, pad.data}, {hi, r0});
            end
            if (xvalid === 1'b1) begin
                check("read", 16'(xread), 16'(rd_q.pop_front()));
            end
            if (done === 1'b1) on_done();
        end
    end

    task automatic run_pass(input int s);
        @(posedge clk_in);
        rst_n_in <= 1'b0;
        stretch <= 3'(s);
        acc <= 8'($urandom);
        r0 <= 8'h80 | 8'($urandom);
        r1 <= 8'($urandom);
        hi <= 8'($urandom);
        for (int i = 0; i < 256; i++) mem.xdata[i] = 8'($urandom);
        repeat (6) @(posedge clk_in);
        s_cur = s;
        idx = 0;
        pc = 0;
        cnt = 0;
        n_ale = 0;
        n_str = 0;
        n_cs = 0;
        rd_q.delete();
        rd_q.push_back(mem.xdata[8'h40]);
        rd_q.push_back(mem.xdata[r0]);
        rst_n_in <= 1'b1;
        for (int k = 0; k < 2000 && idx < N; k++) @(posedge clk_in);
        check("instructions", 16'(idx), 16'(N));
    endtask

    initial begin
        void'($urandom(32'h2806_a9d0));
        for (int i = 0; i < 256; i++) mem.code_mem[i] = 8'h00;
        for (int i = 0; i < 34; i++) mem.code_mem[i] = prog[i];
        run_pass(0);
        run_pass($urandom_range(1, 6));
        run_pass(7);
        conclude();
    end
endmodule
